//--- hdl/mopwm_defines.svh
`ifndef MOPWM_DEFINES_SVH
`define MOPWM_DEFINES_SVH

// Register word addresses on the plain register port
`define MOPWM_ADDR_CTRL      5'h00
`define MOPWM_ADDR_COUNT     5'h01
`define MOPWM_ADDR_PRESCALE  5'h02
`define MOPWM_ADDR_PRECNT    5'h03
`define MOPWM_ADDR_MATCH_CTL 5'h04
`define MOPWM_ADDR_PWM_CTL   5'h05
`define MOPWM_ADDR_RELEASE   5'h06
`define MOPWM_ADDR_IRQ_STAT  5'h07
`define MOPWM_ADDR_IRQ_MASK  5'h08
`define MOPWM_ADDR_CAP_CTL   5'h09
`define MOPWM_ADDR_MATCH0    5'h10

// Control register fields
`define MOPWM_CTRL_EN        0
`define MOPWM_CTRL_RST       1
`define MOPWM_CTRL_PWM       2
`define MOPWM_CTRL_W         3

// Match control: three bits per match register
`define MOPWM_MC_INT         0
`define MOPWM_MC_RST         1
`define MOPWM_MC_STOP        2
`define MOPWM_MC_W           21

// Capture input control: mode 2 bits, input select 1 bit
`define MOPWM_CAP_W          3

`define MOPWM_NUM_MATCH      7
`define MOPWM_NUM_OUT        6
`define MOPWM_ZERO32         32'h0000_0000
`define MOPWM_ONE32          32'h0000_0001

`endif

//--- hdl/mopwm_pkg.sv
package mopwm_pkg;
    typedef logic [31:0] mopwm_word_t;
    typedef logic [4:0] mopwm_addr_t;
    typedef enum logic [1:0] {
        MOPWM_SRC_TIMER = 2'b00,
        MOPWM_SRC_RISE = 2'b01,
        MOPWM_SRC_FALL = 2'b10,
        MOPWM_SRC_BOTH = 2'b11
    } mopwm_src_t;
endpackage

//--- hdl/mopwm_match_if.sv
`timescale 1ns/10ps
interface mopwm_match_if;
    logic [31:0] count;
    logic [31:0] active [7];
    logic [6:0] hit;
    modport core (output count, output active, input hit);
    modport cmp (input count, input active, output hit);
endinterface

//--- hdl/mopwm_match_cmp.sv
`timescale 1ns/10ps
module mopwm_match_cmp (
    mopwm_match_if.cmp bus
);
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_cmp
            assign bus.hit[g] = (bus.count == bus.active[g]);
        end
    endgenerate
endmodule

//--- hdl/mopwm_timer.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "mopwm_defines.svh"

// Contract
// - Period match register match clears the shared counter to zero.
// - Single-edge outputs rise at period match unless held constantly low.
// - One further match register places a single-edge output's falling edge.
// - Each added single-edge output uses one own match register.
// - Double-edge output uses two match registers for rise and fall; here output 1 never rises in double-edge mode.
// - Each added double-edge output uses two more match registers.
// - Seven match registers; six single-edge, three double-edge, or a mix.
// - Per match: continue, stop or reset counter, optional interrupt.
// - Period and width programmable in whole counter ticks, common rate.
// - In PWM mode, new match values act only after software releases them; without PWM mode they act at once.
// - Counter advances on clock or on chosen capture input edges.
// - Without PWM mode it is a plain 32-bit timer with prescaler.
module mopwm_timer (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Register port
    input wire mopwm_pkg::mopwm_addr_t addr_i,
    input wire mopwm_pkg::mopwm_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output mopwm_pkg::mopwm_word_t rdata_o,
    // Pins
    input wire logic [1:0] cap_i,
    output logic [6:1] pwm_o,
    output logic irq_o
);
    import mopwm_pkg::*;

    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Capture pins pass two flops before use
    logic [1:0] cap_m, cap_s, cap_d;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cap_m <= 2'h0;
            cap_s <= 2'h0;
            cap_d <= 2'h0;
        end else begin
            cap_m <= cap_i;
            cap_s <= cap_m;
            cap_d <= cap_s;
        end
    end

    mopwm_match_if mif ();
    mopwm_match_cmp u_cmp (.bus(mif));

    logic [`MOPWM_CTRL_W-1:0] ctrl, next_ctrl;
    mopwm_word_t count, next_count;
    mopwm_word_t prescale, next_prescale;
    mopwm_word_t precnt, next_precnt;
    logic [`MOPWM_MC_W-1:0] mctl, next_mctl;
    logic [13:0] pctl, next_pctl;
    logic [6:0] rel, next_rel;
    logic [6:0] stat, next_stat;
    logic [6:0] mask, next_mask;
    logic [`MOPWM_CAP_W-1:0] capc, next_capc;
    mopwm_word_t shadow [7];
    mopwm_word_t next_shadow [7];
    mopwm_word_t active [7];
    mopwm_word_t next_active [7];
    logic [6:1] pwm, next_pwm;
    mopwm_word_t rdata, next_rdata;
    logic irq, next_irq;

    // Decode used by write and read paths
    function automatic logic is_match(input mopwm_addr_t a);
        return a >= `MOPWM_ADDR_MATCH0 &&
               a < `MOPWM_ADDR_MATCH0 + 5'(`MOPWM_NUM_MATCH);
    endfunction

    assign mif.count = count;
    generate
        for (genvar i = 0; i < 7; i++) begin : g_act
            assign mif.active[i] = ctrl[`MOPWM_CTRL_PWM] ? active[i]
                                                         : shadow[i];
        end
    endgenerate

    logic tick;
    logic cap_edge;
    logic cap_sel;
    logic [6:0] hit;
    logic any_rst, any_stop, period_hit;
    mopwm_src_t src;

    always_comb begin
        src = mopwm_src_t'(capc[1:0]);
        cap_sel = capc[2];
        case (src)
            MOPWM_SRC_RISE: cap_edge = cap_s[cap_sel] & ~cap_d[cap_sel];
            MOPWM_SRC_FALL: cap_edge = ~cap_s[cap_sel] & cap_d[cap_sel];
            MOPWM_SRC_BOTH: cap_edge = cap_s[cap_sel] ^ cap_d[cap_sel];
            default: cap_edge = 1'b1;
        endcase
        tick = ctrl[`MOPWM_CTRL_EN] & ~ctrl[`MOPWM_CTRL_RST] & cap_edge;
    end

    always_comb begin
        // Matches only count on the cycle the prescaler wraps
        hit = mif.hit & {7{tick && precnt == prescale}};
        any_rst = 1'b0;
        any_stop = 1'b0;
        for (int m = 0; m < 7; m++) begin
            any_rst = any_rst | (hit[m] & mctl[3*m+`MOPWM_MC_RST]);
            any_stop = any_stop | (hit[m] & mctl[3*m+`MOPWM_MC_STOP]);
        end
        period_hit = hit[0] & ctrl[`MOPWM_CTRL_PWM];

        next_ctrl = ctrl;
        next_prescale = prescale;
        next_mctl = mctl;
        next_pctl = pctl;
        next_rel = rel;
        next_mask = mask;
        next_capc = capc;
        next_shadow = shadow;
        next_active = active;
        next_count = count;
        next_precnt = precnt;
        next_pwm = pwm;
        next_rdata = `MOPWM_ZERO32;

        if (ctrl[`MOPWM_CTRL_RST]) begin
            next_count = `MOPWM_ZERO32;
            next_precnt = `MOPWM_ZERO32;
        end else if (tick) begin
            if (precnt == prescale) begin
                next_precnt = `MOPWM_ZERO32;
                if (period_hit || any_rst)
                    next_count = `MOPWM_ZERO32;
                else if (any_stop)
                    // A stop match freezes the count on the matched value
                    next_count = count;
                else
                    next_count = count + `MOPWM_ONE32;
            end else begin
                next_precnt = precnt + `MOPWM_ONE32;
            end
        end
        if (any_stop)
            next_ctrl[`MOPWM_CTRL_EN] = 1'b0;

        // Released shadows go live at the cycle boundary in PWM mode, and at once without PWM mode
        if (period_hit || !ctrl[`MOPWM_CTRL_PWM]) begin
            for (int m = 0; m < 7; m++)
                if (rel[m]) begin
                    next_active[m] = shadow[m];
                    next_rel[m] = 1'b0;
                end
        end

        // Output n: single edge uses match n; double uses n-1 and n, except output 1, which never rises in double mode
        for (int n = 1; n < 7; n++) begin
            if (!ctrl[`MOPWM_CTRL_PWM] || !pctl[n+7]) begin
                next_pwm[n] = 1'b0;
            end else if (pctl[n]) begin
                if (hit[n])
                    next_pwm[n] = 1'b0;
                else if (hit[n-1] && n > 1)
                    next_pwm[n] = 1'b1;
            end else begin
                if (hit[n])
                    next_pwm[n] = 1'b0;
                else if (period_hit)
                    next_pwm[n] = 1'b1;
            end
        end

        if (wr_i) begin
            case (addr_i)
                `MOPWM_ADDR_CTRL: next_ctrl = wdata_i[`MOPWM_CTRL_W-1:0];
                `MOPWM_ADDR_COUNT: next_count = wdata_i;
                `MOPWM_ADDR_PRESCALE: next_prescale = wdata_i;
                `MOPWM_ADDR_PRECNT: next_precnt = wdata_i;
                `MOPWM_ADDR_MATCH_CTL: next_mctl = wdata_i[`MOPWM_MC_W-1:0];
                `MOPWM_ADDR_PWM_CTL: next_pctl = wdata_i[13:0];
                `MOPWM_ADDR_RELEASE: next_rel = rel | wdata_i[6:0];
                `MOPWM_ADDR_IRQ_MASK: next_mask = wdata_i[6:0];
                `MOPWM_ADDR_CAP_CTL: next_capc = wdata_i[`MOPWM_CAP_W-1:0];
                default: begin
                    if (is_match(addr_i))
                        next_shadow[3'(addr_i - `MOPWM_ADDR_MATCH0)] =
                            wdata_i;
                end
            endcase
        end

        if (rd_i) begin
            case (addr_i)
                `MOPWM_ADDR_CTRL: next_rdata = 32'(ctrl);
                `MOPWM_ADDR_COUNT: next_rdata = count;
                `MOPWM_ADDR_PRESCALE: next_rdata = prescale;
                `MOPWM_ADDR_PRECNT: next_rdata = precnt;
                `MOPWM_ADDR_MATCH_CTL: next_rdata = 32'(mctl);
                `MOPWM_ADDR_PWM_CTL: next_rdata = 32'(pctl);
                `MOPWM_ADDR_RELEASE: next_rdata = 32'(rel);
                `MOPWM_ADDR_IRQ_STAT: next_rdata = 32'(stat);
                `MOPWM_ADDR_IRQ_MASK: next_rdata = 32'(mask);
                `MOPWM_ADDR_CAP_CTL: next_rdata = 32'(capc);
                default: begin
                    if (is_match(addr_i))
                        next_rdata = shadow[3'(addr_i - `MOPWM_ADDR_MATCH0)];
                end
            endcase
        end

        // Read clears status, but a new match in the same cycle survives
        next_stat = stat;
        if (rd_i && addr_i == `MOPWM_ADDR_IRQ_STAT)
            next_stat = 7'h00;
        for (int m = 0; m < 7; m++)
            if (hit[m] && mctl[3*m+`MOPWM_MC_INT])
                next_stat[m] = 1'b1;
        next_irq = |(next_stat & mask);
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
            count <= `MOPWM_ZERO32;
            prescale <= `MOPWM_ZERO32;
            precnt <= `MOPWM_ZERO32;
            mctl <= '0;
            pctl <= 14'h0000;
            rel <= 7'h00;
            stat <= 7'h00;
            mask <= 7'h00;
            capc <= '0;
            shadow <= '{default: `MOPWM_ZERO32};
            active <= '{default: `MOPWM_ZERO32};
            pwm <= 6'h00;
            rdata <= `MOPWM_ZERO32;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            count <= next_count;
            prescale <= next_prescale;
            precnt <= next_precnt;
            mctl <= next_mctl;
            pctl <= next_pctl;
            rel <= next_rel;
            stat <= next_stat;
            mask <= next_mask;
            capc <= next_capc;
            shadow <= next_shadow;
            active <= next_active;
            pwm <= next_pwm;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    assign rdata_o = rdata;
    assign pwm_o = pwm;
    assign irq_o = irq;
endmodule

//--- dv/mopwm_timer_asserts.sv
`timescale 1ns/10ps
module mopwm_timer_asserts (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Register port and pins
    input wire mopwm_pkg::mopwm_addr_t addr_i,
    input wire mopwm_pkg::mopwm_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire mopwm_pkg::mopwm_word_t rdata_o,
    input wire logic [6:1] pwm_o,
    input wire logic irq_o
);
    import mopwm_pkg::*;
    // Software's view: last word written to each address
    mopwm_word_t sh [32];
    logic clr;
    logic [5:0] en;
    assign clr = (rd_i && addr_i == 5'h07) || (wr_i && addr_i == 5'h08);
    assign en = sh[5][13:8];
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i)
            sh <= '{default: '0};
        else if (wr_i)
            sh[addr_i] <= wdata_i;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    property p_idle; !rd_i |=> rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_unmap; rd_i && addr_i == 5'h1f |=> rdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_back;
        rd_i && (addr_i == 5'h02 || addr_i inside {[5'h10:5'h16]})
        |=> rdata_o == $past(sh[addr_i]);
    endproperty
    a_back: assert property (p_back) else $error("readback");
    property p_cnt;
        rd_i && addr_i == 5'h01 && !sh[0][0] ##1 rd_i && addr_i == 5'h01
        |=> rdata_o == $past(rdata_o);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count moved");
    property p_irqm; irq_o |-> $past(sh[8][6:0]) != 7'h0; endproperty
    a_irqm: assert property (p_irqm) else $error("masked irq");
    property p_irqh; irq_o && !clr && !$past(clr) |=> irq_o; endproperty
    a_irqh: assert property (p_irqh) else $error("irq dropped");
    property p_pwmen;
        (pwm_o & ~(en | $past(en) | $past(en, 2))) == 6'h00;
    endproperty
    a_pwmen: assert property (p_pwmen) else $error("output on");
    property p_rst;
        $rose(arst_n_i) |-> (pwm_o == 6'h00 && !irq_o)[*2];
    endproperty
    a_rst: assert property (p_rst) else $error("out after reset");
    c_irq: cover property ($rose(irq_o));
    c_neg: cover property ($rose(pwm_o[2]));
    c_cnt: cover property (rd_i && addr_i == 5'h01 ##1 rd_i);
endmodule

//--- dv/mopwm_load.sv
`timescale 1ns/10ps
module mopwm_load (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Driven outputs, and what the load measured
    input wire logic [6:1] pwm_i,
    output logic [7:0] per_o [6:1],
    output logic [7:0] hi_o [6:1]
);
    logic [6:1] prev;
    logic [7:0] since [6:1];
    logic [7:0] ht [6:1];
    // Last full period and pulse length in cycles; unknown until seen
    always_ff @(posedge clock_i) begin
        prev <= arst_n_i ? pwm_i : 6'h00;
        for (int n = 1; n <= 6; n++) begin
            since[n] <= since[n] + 8'h01;
            ht[n] <= ht[n] + 8'(pwm_i[n]);
            if (pwm_i[n] && !prev[n]) begin
                per_o[n] <= since[n];
                since[n] <= 8'h01;
                ht[n] <= 8'h01;
            end
            if (!pwm_i[n] && prev[n])
                hi_o[n] <= ht[n];
        end
    end
endmodule

//--- dv/multi_output_pwm_timer_tb.sv
`timescale 1ns/10ps
module multi_output_pwm_timer_tb;
    import mopwm_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    mopwm_addr_t addr_i = 5'h00;
    mopwm_word_t wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_d = 1'b0;
    logic [1:0] cap_i = 2'h0;
    mopwm_word_t rdata_o;
    logic [6:1] pwm_o;
    logic irq_o;
    logic [7:0] per [6:1];
    logic [7:0] hi [6:1];
    mopwm_word_t exp_q [$];
    mopwm_word_t rnd = 32'hecbaf5c5;
    mopwm_word_t m;
    int mismatches = 0;
    int n_tests = 0;
    always #25 clock_i = ~clock_i;
    mopwm_timer dut (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .cap_i, .pwm_o, .irq_o);
    mopwm_load load (.clock_i, .arst_n_i, .pwm_i(pwm_o), .per_o(per),
        .hi_o(hi));
    function automatic mopwm_word_t lfsr(input mopwm_word_t s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
    endfunction
    task automatic check(input mopwm_word_t got, input mopwm_word_t exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Raises the strobe at the next edge and leaves it up; a read notes what it expects
    task bus(input logic w, input mopwm_addr_t a, input mopwm_word_t d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        if (!w)
            exp_q.push_back(d);
    endtask
    task go(input logic w, input mopwm_addr_t a, input mopwm_word_t d);
        bus(w, a, d);
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task chk_pwm(input mopwm_word_t a, input mopwm_word_t b);
        repeat (40) @(posedge clock_i);
        check(32'(per[1]), 32'ha);
        check(32'(per[2]), 32'ha);
        check(32'(hi[1]), a);
        check(32'(hi[2]), b);
    endtask
    always @(posedge clock_i) begin
        if (rd_d)
            check(rdata_o, exp_q.pop_front());
        rd_d <= rd_i;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        go(1'b1, 5'h1f, 32'hffff_ffff);
        go(1'b0, 5'h1f, 32'h0);
        // Huge match values keep them out of the low counts used below
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            m = rnd | 32'h8000_0000;
            go(1'b1, 5'h10 + 5'(i), m);
            go(1'b0, 5'h10 + 5'(i), m);
        end
        go(1'b1, 5'h09, 32'h1);
        go(1'b1, 5'h00, 32'h2);
        go(1'b1, 5'h00, 32'h1);
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            repeat (4) @(posedge clock_i);
            cap_i <= {rnd[0], ~cap_i[0]};
        end
        repeat (8) @(posedge clock_i);
        go(1'b0, 5'h01, 32'h5);
        go(1'b1, 5'h09, 32'h0);
        for (int p = 0; p < 4; p += 3) begin
            rnd = lfsr(rnd);
            m = 32'(rnd[3:0]) + 32'h5;
            go(1'b1, 5'h00, 32'h2);
            go(1'b1, 5'h02, 32'(p));
            go(1'b1, 5'h10, m);
            go(1'b1, 5'h04, 32'h5);
            go(1'b1, 5'h08, 32'h1);
            go(1'b1, 5'h00, 32'h1);
            for (int k = 0; k < 400 && irq_o !== 1'b1; k++)
                @(posedge clock_i);
            check(32'(irq_o), 32'h1);
            if (irq_o !== 1'b1)
                print_verdict();
            go(1'b0, 5'h00, 32'h0);
            go(1'b1, 5'h00, 32'h0);
            bus(1'b0, 5'h01, m);
            go(1'b0, 5'h01, m);
            go(1'b0, 5'h07, 32'h1);
            go(1'b0, 5'h07, 32'h0);
            check(32'(irq_o), 32'h0);
        end
        go(1'b1, 5'h00, 32'h2);
        go(1'b1, 5'h04, 32'h0);
        go(1'b1, 5'h02, 32'h0);
        go(1'b1, 5'h05, 32'h304);
        go(1'b1, 5'h10, 32'h9);
        go(1'b1, 5'h11, 32'h4);
        go(1'b1, 5'h12, 32'h7);
        go(1'b1, 5'h06, 32'h7f);
        go(1'b1, 5'h00, 32'h5);
        chk_pwm(32'h5, 32'h3);
        go(1'b1, 5'h11, 32'h6);
        go(1'b1, 5'h12, 32'h1);
        chk_pwm(32'h5, 32'h3);
        go(1'b1, 5'h06, 32'h7f);
        chk_pwm(32'h7, 32'h5);
        go(1'b1, 5'h05, 32'h104);
        repeat (3) @(posedge clock_i);
        check(32'(pwm_o[2]), 32'h0);
        print_verdict();
    end
endmodule
bind mopwm_timer mopwm_timer_asserts u_chk (.clock_i, .arst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .pwm_o, .irq_o);
